// File: hw/otp_option_defines.svh
// Constants for the one-time-programmable option map and programming-mode addressing
`ifndef OTP_OPTION_DEFINES_SVH
`define OTP_OPTION_DEFINES_SVH

// ==========================================================================
// Programming-mode address windows
`define PROG_BASE_8K 15'h6000
`define PROG_BASE_16K 15'h4000
`define CHIP_BASE_8K 16'he000
`define CHIP_BASE_16K 16'hc000
`define OPT_FIRST_ADDR 15'h3ff0
`define OPT_LAST_ADDR 15'h3ff6
`define OPT_COUNT 7

// ==========================================================================
// Option byte layout
`define OPT_IDX_CLOCK 0
`define OPT_IDX_PORT0 1
`define OPT_IDX_PORT1 2
`define OPT_IDX_PORT3 3
`define OPT_BIT_ONE_CLOCK 4
`define OPT_BIT_RESET_OUT 3
`define OPT_BIT_POWER_ON 2
`define OPT_BLANK 8'hff

// ==========================================================================
// Stabilization wait exponents
`define WAIT_EXP_0 5'h03
`define WAIT_EXP_1 5'h0c
`define WAIT_EXP_2 5'h10
`define WAIT_EXP_3 5'h12

`endif

// File: hw/otp_option_loader.sv
// PROM programming-mode access, option byte store and option decode
//
// Implementation choices: strobed register access and the address map.
`include "otp_option_defines.svh"

// Notes on behaviour
// - 8K variant: single-chip E000-FFFF appears at programming addresses 6000-7FFF.
// - 16K variant: single-chip C000-FFFF appears at programming addresses 4000-7FFF.
// - First option bit4 one clock, bit3 reset-pin output, bit2 power-on reset.
// - Option bytes two to four: per-pin pull-ups on ports 0, 1, 3; blank reads 1.
// - 16K variant: vacant option bits are stored and read back but configure nothing.
// - No electronic-signature mode; programmer must not depend on it.
module otp_option_loader #(
  parameter bit BIG_VARIANT = 1'b1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire otp_option_pkg::prog_req_t prog_req,
  output logic [7:0] prog_rdata,
  output logic prog_rvalid,
  input wire logic [15:0] chip_addr,
  input wire logic chip_read,
  output logic [7:0] chip_rdata,
  output otp_option_pkg::option_cfg_t cfg,
  output logic [4:0] wait_exp,
  output logic cfg_valid
);

  localparam int AW = 14;
  localparam int DEPTH = 16384;

  // ==========================================================================
  // Address translation
  function automatic logic in_program(input logic [14:0] a);
    if (BIG_VARIANT) begin
      in_program = a >= `PROG_BASE_16K;
    end else begin
      in_program = a >= `PROG_BASE_8K;
    end
  endfunction

  function automatic logic is_option(input logic [14:0] a);
    is_option = BIG_VARIANT && a >= `OPT_FIRST_ADDR && a <= `OPT_LAST_ADDR;
  endfunction

  function automatic logic [AW-1:0] array_index(input logic [14:0] a);
    array_index = a[AW-1:0];
  endfunction

  // Single-chip offset equals programming offset; only bit 15 differs
  logic chip_in_range;
  logic [14:0] chip_as_prog;
  always_comb begin
    chip_as_prog = chip_addr[14:0];
    if (BIG_VARIANT) begin
      chip_in_range = chip_addr >= `CHIP_BASE_16K;
    end else begin
      chip_in_range = chip_addr >= `CHIP_BASE_8K;
    end
  end

  // ==========================================================================
  // Program array
  logic prom_wen;
  logic [AW-1:0] prom_raddr;
  logic [7:0] prom_rdata;

  assign prom_wen = prog_req.write && in_program(prog_req.addr);
  assign prom_raddr = prog_req.read ? array_index(prog_req.addr) : array_index(chip_as_prog);

  otp_prom_array #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) otp_prom_array_i (
    .mclk(mclk),
    .waddr(array_index(prog_req.addr)),
    .wdata(prog_req.wdata),
    .wen(prom_wen),
    .raddr(prom_raddr),
    .rdata(prom_rdata)
  );

  // ==========================================================================
  // Option bytes: one-time cells, blank is all ones, not cleared by reset
  logic [7:0] opt [`OPT_COUNT];
  logic [7:0] next_opt [`OPT_COUNT];
  logic [2:0] opt_idx;

  assign opt_idx = 3'(prog_req.addr - `OPT_FIRST_ADDR);

  // Index clamped so a read outside the option window never picks a missing cell
  logic [2:0] opt_sel;
  always_comb begin
    if (is_option(prog_req.addr)) begin
      opt_sel = opt_idx;
    end else begin
      opt_sel = 3'h0;
    end
  end

  initial begin
    for (int i = 0; i < `OPT_COUNT; i++) begin
      opt[i] = `OPT_BLANK;
    end
  end

  always_comb begin
    for (int i = 0; i < `OPT_COUNT; i++) begin
      next_opt[i] = opt[i];
    end
    // All bits, vacant ones included, are ANDed with the written byte
    if (prog_req.write && is_option(prog_req.addr)) begin
      next_opt[opt_idx] = opt[opt_idx] & prog_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < `OPT_COUNT; i++) begin
      opt[i] <= next_opt[i];
    end
  end

  // ==========================================================================
  // Read path; no signature mode, so no special identifier addresses
  logic rd_opt;
  logic rd_prog;
  logic [7:0] rd_opt_byte;
  logic chip_pend;
  logic chip_ok;
  logic next_rd_opt;
  logic next_rd_prog;
  logic [7:0] next_rd_opt_byte;
  logic next_prog_rvalid;
  logic next_chip_pend;
  logic next_chip_ok;

  always_comb begin
    next_rd_opt = prog_req.read && is_option(prog_req.addr);
    next_rd_prog = prog_req.read && in_program(prog_req.addr);
    next_rd_opt_byte = opt[opt_sel];
    next_prog_rvalid = prog_req.read;
    next_chip_pend = chip_read && !prog_req.read;
    next_chip_ok = chip_in_range;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_opt <= 1'b0;
      rd_prog <= 1'b0;
      rd_opt_byte <= `OPT_BLANK;
      prog_rvalid <= 1'b0;
      chip_pend <= 1'b0;
      chip_ok <= 1'b0;
    end else begin
      rd_opt <= next_rd_opt;
      rd_prog <= next_rd_prog;
      rd_opt_byte <= next_rd_opt_byte;
      prog_rvalid <= next_prog_rvalid;
      chip_pend <= next_chip_pend;
      chip_ok <= next_chip_ok;
    end
  end

  // Unused programming addresses read blank, as an erased part would
  always_comb begin
    if (rd_opt) begin
      prog_rdata = rd_opt_byte;
    end else if (rd_prog) begin
      prog_rdata = prom_rdata;
    end else begin
      prog_rdata = `OPT_BLANK;
    end
    chip_rdata = (chip_pend && chip_ok) ? prom_rdata : `OPT_BLANK;
  end

  // ==========================================================================
  // Option decode, captured on the first edge after reset release
  function automatic logic [4:0] wait_exponent(input otp_option_pkg::osc_wait_t w);
    unique case (w)
      otp_option_pkg::WAIT_2P3: wait_exponent = `WAIT_EXP_0;
      otp_option_pkg::WAIT_2P12: wait_exponent = `WAIT_EXP_1;
      otp_option_pkg::WAIT_2P16: wait_exponent = `WAIT_EXP_2;
      otp_option_pkg::WAIT_2P18: wait_exponent = `WAIT_EXP_3;
    endcase
  endfunction

  otp_option_pkg::option_cfg_t next_cfg;
  otp_option_pkg::option_cfg_t decoded;
  logic next_cfg_valid;
  logic [4:0] next_wait_exp;

  always_comb begin
    decoded.osc_wait = otp_option_pkg::osc_wait_t'(opt[`OPT_IDX_CLOCK][1:0]);
    decoded.one_clock = opt[`OPT_IDX_CLOCK][`OPT_BIT_ONE_CLOCK];
    decoded.reset_pin_out = opt[`OPT_IDX_CLOCK][`OPT_BIT_RESET_OUT];
    decoded.power_on_reset = opt[`OPT_IDX_CLOCK][`OPT_BIT_POWER_ON];
    decoded.pullup_port0 = opt[`OPT_IDX_PORT0];
    decoded.pullup_port1 = opt[`OPT_IDX_PORT1];
    decoded.pullup_port3 = opt[`OPT_IDX_PORT3];
    next_cfg = cfg;
    next_wait_exp = wait_exp;
    next_cfg_valid = 1'b1;
    // Frozen once valid so late programming cannot disturb a running chip
    if (!cfg_valid) begin
      next_cfg = decoded;
      next_wait_exp = wait_exponent(decoded.osc_wait);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg <= '1;
      wait_exp <= `WAIT_EXP_3;
      cfg_valid <= 1'b0;
    end else begin
      cfg <= next_cfg;
      wait_exp <= next_wait_exp;
      cfg_valid <= next_cfg_valid;
    end
  end

  // ==========================================================================
  // Checks
  a_cfg_hold_stable: assert property (@(posedge mclk) disable iff (reset)
    cfg_valid |=> $stable(cfg)) else $error("Option settings changed after capture");
  a_cfg_capture_once: assert property (@(posedge mclk) disable iff (reset)
    !cfg_valid |=> cfg_valid && cfg.pullup_port0 == $past(opt[1])) else $error("Capture wrong");
  a_wait_map_fast: assert property (@(posedge mclk) disable iff (reset)
    cfg_valid && cfg.osc_wait == otp_option_pkg::WAIT_2P3 |-> wait_exp == 5'h03) else $error("Wait 2^3 wrong");
  a_wait_map_slow: assert property (@(posedge mclk) disable iff (reset)
    cfg_valid && cfg.osc_wait == otp_option_pkg::WAIT_2P18 |-> wait_exp == 5'h12) else $error("Wait 2^18 wrong");
  a_opt_readback: assert property (@(posedge mclk) disable iff (reset)
    prog_req.read && is_option(prog_req.addr) |=> prog_rvalid && prog_rdata == $past(opt[opt_idx]))
    else $error("Option readback wrong");
  a_opt_write_clears: assert property (@(posedge mclk)
    prog_req.write && is_option(prog_req.addr) |=> (opt[$past(opt_idx)] & ~$past(prog_req.wdata)) == 8'h00)
    else $error("Option write lost");
  a_read_latency: assert property (@(posedge mclk) disable iff (reset)
    prog_req.read |=> prog_rvalid ##1 !prog_rvalid || $past(prog_req.read))
    else $error("Read strobe latency wrong");
  a_low_addr_blank: assert property (@(posedge mclk) disable iff (reset)
    prog_req.read && !in_program(prog_req.addr) && !is_option(prog_req.addr) |=> prog_rdata == 8'hff)
    else $error("Unused address not blank");
  a_chip_out_range: assert property (@(posedge mclk) disable iff (reset)
    chip_read && !prog_req.read && !chip_in_range |=> chip_rdata == 8'hff)
    else $error("Out-of-range chip read not blank");

  // ==========================================================================
  // Field decode, reset state and strobe timing
  a_clock_select: assert property (@(posedge mclk) disable iff (reset)
    !cfg_valid |=> cfg.one_clock == $past(opt[`OPT_IDX_CLOCK][`OPT_BIT_ONE_CLOCK]))
    else $error("Clock select capture wrong");
  a_reset_out_sel: assert property (@(posedge mclk) disable iff (reset)
    !cfg_valid |=> cfg.reset_pin_out == $past(opt[`OPT_IDX_CLOCK][`OPT_BIT_RESET_OUT]))
    else $error("Reset pin output capture wrong");
  a_power_on_sel: assert property (@(posedge mclk) disable iff (reset)
    !cfg_valid |=> cfg.power_on_reset == $past(opt[`OPT_IDX_CLOCK][`OPT_BIT_POWER_ON]))
    else $error("Power-on reset capture wrong");
  a_pullup_port1: assert property (@(posedge mclk) disable iff (reset)
    !cfg_valid |=> cfg.pullup_port1 == $past(opt[`OPT_IDX_PORT1]))
    else $error("Port 1 pull-up capture wrong");
  a_pullup_port3: assert property (@(posedge mclk) disable iff (reset)
    !cfg_valid |=> cfg.pullup_port3 == $past(opt[`OPT_IDX_PORT3]))
    else $error("Port 3 pull-up capture wrong");
  a_wait_map_mid: assert property (@(posedge mclk) disable iff (reset)
    cfg_valid && cfg.osc_wait == otp_option_pkg::WAIT_2P12 |-> wait_exp == 5'h0c)
    else $error("Wait 2^12 wrong");
  a_wait_map_long: assert property (@(posedge mclk) disable iff (reset)
    cfg_valid && cfg.osc_wait == otp_option_pkg::WAIT_2P16 |-> wait_exp == 5'h10)
    else $error("Wait 2^16 wrong");
  a_reset_state: assert property (@(posedge mclk)
    reset |=> !cfg_valid && !prog_rvalid && wait_exp == 5'h12)
    else $error("Reset state wrong");
  a_rvalid_idle: assert property (@(posedge mclk) disable iff (reset)
    !prog_req.read |=> !prog_rvalid)
    else $error("Read valid without strobe");
  a_chip_collide: assert property (@(posedge mclk) disable iff (reset)
    chip_read && prog_req.read |=> chip_rdata == 8'hff)
    else $error("Colliding chip read not blank");

  c_opt_write: cover property (@(posedge mclk) prog_req.write && is_option(prog_req.addr));
  c_prog_read: cover property (@(posedge mclk) prog_req.read && in_program(prog_req.addr));
  c_chip_read: cover property (@(posedge mclk) chip_read && chip_in_range);
  c_capture: cover property (@(posedge mclk) $rose(cfg_valid));

endmodule

// File: hw/otp_option_pkg.sv
// Types shared by the option loader, the programmer model and the bench
package otp_option_pkg;

  typedef enum logic [1:0] {
    WAIT_2P3 = 2'b00,
    WAIT_2P12 = 2'b01,
    WAIT_2P16 = 2'b10,
    WAIT_2P18 = 2'b11
  } osc_wait_t;

  typedef struct packed {
    osc_wait_t osc_wait;
    logic one_clock;
    logic reset_pin_out;
    logic power_on_reset;
    logic [7:0] pullup_port0;
    logic [7:0] pullup_port1;
    logic [7:0] pullup_port3;
  } option_cfg_t;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } prog_req_t;

endpackage

// File: hw/otp_prom_array.sv
// Byte-wide one-time-programmable storage array, blank value all ones
`include "otp_option_defines.svh"

module otp_prom_array #(
  parameter int DEPTH = 16384,
  parameter int AW = 14
) (
  input wire logic mclk,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic wen,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  // Blank cells read as ones; programming only clears bits
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = `OPT_BLANK;
    end
  end

  always_ff @(posedge mclk) begin
    if (wen) begin
      mem[waddr] <= mem[waddr] & wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// File: verification/otp_option_map_and_prom_addressing_bench.sv
// Self-checking bench for the option loader, 16K and 8K variants
module otp_option_map_and_prom_addressing_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] chip_addr = 16'h0000;
  logic chip_read = 1'b0;
  otp_option_pkg::prog_req_t prog_req;
  otp_option_pkg::option_cfg_t cfg;
  logic [7:0] prog_rdata;
  logic prog_rvalid;
  logic [7:0] rd_big;
  logic [7:0] rd_small;
  logic [4:0] wait_exp;
  logic cfg_valid;
  int bad_count = 0;
  int n_tests = 0;

  always #4 mclk = ~mclk;

  // ==========================================================================
  // Instances; both variants share the programmer and the CPU port
  prom_programmer_model prom_programmer_model_i (.mclk(mclk), .prog_req(prog_req),
    .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid));
  otp_option_loader #(.BIG_VARIANT(1'b1)) otp_option_loader_i (.mclk(mclk), .reset(reset),
    .prog_req(prog_req), .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid), .chip_addr(chip_addr),
    .chip_read(chip_read), .chip_rdata(rd_big), .cfg(cfg), .wait_exp(wait_exp), .cfg_valid(cfg_valid));
  otp_option_loader #(.BIG_VARIANT(1'b0)) otp_option_loader_small_i (.mclk(mclk), .reset(reset),
    .prog_req(prog_req), .prog_rdata(), .prog_rvalid(), .chip_addr(chip_addr),
    .chip_read(chip_read), .chip_rdata(rd_small), .cfg(), .wait_exp(), .cfg_valid());

  // ==========================================================================
  // Compare and helper tasks
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_cfg(input otp_option_pkg::option_cfg_t e);
    n_tests++;
    if (cfg !== e) begin
      bad_count++;
      $display("mismatch cfg expected %h seen %h", e, cfg);
    end
  endtask

  task automatic prog_chk(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] d;
    prom_programmer_model_i.pread(a, d);
    chk_byte("prog read", e, d);
  endtask

  task automatic chip_chk(input logic [15:0] a, input logic [7:0] eb, input logic [7:0] es);
    @(posedge mclk);
    chip_addr <= a;
    chip_read <= 1'b1;
    @(posedge mclk);
    chip_read <= 1'b0;
    chip_addr <= ~a;
    #1;
    chk_byte("chip big", eb, rd_big);
    chk_byte("chip small", es, rd_small);
  endtask

  // Capture happens at the first edge with reset low
  task automatic do_reset;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    chk_byte("cfg valid", 8'h01, {7'h00, cfg_valid});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_blank;
    chk_cfg('1);
    chk_byte("wait exp", 8'h12, {3'h0, wait_exp});
    prog_chk(15'h3ff4, 8'hff);
  endtask

  task automatic t_map;
    prom_programmer_model_i.pwrite(15'h4000, 8'ha5);
    prom_programmer_model_i.pwrite(15'h6000, 8'h3c);
    prom_programmer_model_i.pwrite(15'h7fff, 8'h5a);
    prom_programmer_model_i.pwrite(15'h2000, 8'h00);
    chip_chk(16'hc000, 8'ha5, 8'hff);
    chip_chk(16'he000, 8'h3c, 8'h3c);
    chip_chk(16'hffff, 8'h5a, 8'h5a);
    chip_chk(16'hbfff, 8'hff, 8'hff);
    prog_chk(15'h4000, 8'ha5);
    prog_chk(15'h2000, 8'hff);
  endtask

  task automatic t_options;
    prom_programmer_model_i.pwrite(15'h3ff0, 8'ha9);
    prom_programmer_model_i.pwrite(15'h3ff1, 8'h0f);
    prom_programmer_model_i.pwrite(15'h3ff2, 8'h81);
    prom_programmer_model_i.pwrite(15'h3ff3, 8'h3c);
    prom_programmer_model_i.pwrite(15'h3ff4, 8'h55);
    prom_programmer_model_i.pwrite(15'h3ff6, 8'h00);
    chk_cfg('1);
    prog_chk(15'h3ff0, 8'ha9);
    prog_chk(15'h3ff4, 8'h55);
    prog_chk(15'h3ff6, 8'h00);
    do_reset();
    chk_cfg('{otp_option_pkg::WAIT_2P12, 1'b0, 1'b1, 1'b0, 8'h0f, 8'h81, 8'h3c});
    chk_byte("wait exp", 8'h0c, {3'h0, wait_exp});
    // Cells only clear, so the codes are visited from blank downwards
    prom_programmer_model_i.pwrite(15'h3ff0, 8'ha8);
    do_reset();
    chk_cfg('{otp_option_pkg::WAIT_2P3, 1'b0, 1'b1, 1'b0, 8'h0f, 8'h81, 8'h3c});
    chk_byte("wait exp", 8'h03, {3'h0, wait_exp});
  endtask

  // ==========================================================================
  // Verdict, main sequence and watchdog
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    t_blank();
    t_map();
    t_options();
    stop_test();
  end

  // Whole sequence needs under a hundred cycles
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    stop_test();
  end
endmodule

// File: verification/prom_programmer_model.sv
// Behavioural parallel PROM programmer driving the programming port
module prom_programmer_model (
  input wire logic mclk,
  output otp_option_pkg::prog_req_t prog_req,
  input wire logic [7:0] prog_rdata,
  input wire logic prog_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Bus cycles
  // No signature query is ever issued; the part is chosen by the user
  initial prog_req = '0;

  // Option bytes go out through this same program write
  task automatic pwrite(input logic [14:0] a, input logic [7:0] d);
    @(posedge mclk);
    prog_req.addr <= a;
    prog_req.wdata <= d;
    prog_req.write <= 1'b1;
    @(posedge mclk);
    prog_req.write <= 1'b0;
    // Released lines must not keep showing the old byte
    prog_req.wdata <= ~d;
  endtask

  task automatic pread(input logic [14:0] a, output logic [7:0] d);
    @(posedge mclk);
    prog_req.addr <= a;
    prog_req.read <= 1'b1;
    @(posedge mclk);
    prog_req.read <= 1'b0;
    prog_req.addr <= ~a;
    #1;
    d = prog_rvalid ? prog_rdata : 8'hxx;
  endtask
endmodule
